// >>> rtl/clb_seq_end.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Pulse core resets together for 500 ns
// - Map resets cover every used channel
// - Synced receiver state field reads 0x3
// - Synced counter field reads 0x2
// - Hyperframe valid rises before basic-frame valid
// - Link ready only after all four seen
// - Write 0x21 to link configuration
// - Write 0x301 to channel count register
// - Write 0x0C to mapping configuration
// - Slave transmits only after receive lock
// - Slave needs a real master partner
// - Receiver state steps 1, 2, 3
// - Link transmission already runs from the 0x1 reset value; 0x21 is written after link up
module clb_seq_end import clb_pkg::*; #(
	parameter int unsigned N_CH = NUM_CH
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	clb_link_if.seq lnk,
	input wire logic [AXI_AW-1:0] i_axi_awaddr,
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	output logic [1:0] o_axi_bresp,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	input wire logic [AXI_AW-1:0] i_axi_araddr,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	output logic o_irq,
	output logic o_link_up
);
	logic [7:0] rxs;
	clb_host_e st_q;
	logic [15:0] cnt_q;
	logic rst_q;
	logic wr_req_q;
	logic [15:0] wr_addr_q;
	logic [31:0] wr_data_q;
	logic link_up_q;
	logic done_q;
	logic start_q;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic stat_rd;
	logic synced;

	// ********************
	// Status sampling
	// ********************
	clb_sync #(.WIDTH(RXS_W)) u_rxs_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_async(lnk.rx_status),
		.o_sync(rxs)
	);

	assign synced = rxs[RXS_STATE_LSB +: 2] == RX_HYPERFRAME_SYNCHRONISED && rxs[RXS_CNT_LSB +: 3] == CNT_AT_SYNC;

	// ********************
	// Bring-up sequence
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			st_q <= H_RST;
			cnt_q <= '0;
		end
		else if (start_q)
		begin
			st_q <= H_RST;
			cnt_q <= '0;
		end
		else
		begin
			unique case (st_q)
				H_RST:
				begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q >= 16'(RST_CYC - 1))
						st_q <= H_WSYNC;
				end
				H_WSYNC:
					if (synced)
						st_q <= H_WHFN;
				H_WHFN:
					if (synced && rxs[RXS_HFN_BIT])
						st_q <= H_WBFN;
				H_WBFN:
					if (synced && rxs[RXS_HFN_BIT] && rxs[RXS_BFN_BIT])
						st_q <= H_WLINK;
				H_WLINK:
					if (lnk.wr_ack)
						st_q <= H_WCHN;
				H_WCHN:
					if (lnk.wr_ack)
						st_q <= H_WMAP;
				H_WMAP:
					if (lnk.wr_ack)
						st_q <= H_DONE;
				H_DONE:
					st_q <= H_DONE;
			endcase
		end
	end

	// Resets leave a flop of their own, not the state register, so they come out glitch free
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			rst_q <= 1'b1;
		else
			rst_q <= (st_q == H_RST && !(cnt_q >= 16'(RST_CYC - 1))) || start_q;
	end

	// ********************
	// Core register writes
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || start_q)
		begin
			wr_req_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end
		else if (wr_req_q)
		begin
			if (lnk.wr_ack)
				wr_req_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				H_WLINK:
				begin
					wr_req_q <= 1'b1;
					wr_addr_q <= LINK_CFG_ADDR;
					wr_data_q <= LINK_CFG_VAL;
				end
				H_WCHN:
				begin
					wr_req_q <= 1'b1;
					wr_addr_q <= CHN_CFG_ADDR;
					wr_data_q <= CHN_CFG_VAL;
				end
				H_WMAP:
				begin
					wr_req_q <= 1'b1;
					wr_addr_q <= MAP_CFG_ADDR;
					wr_data_q <= MAP_CFG_VAL;
				end
				H_RST, H_WSYNC, H_WHFN, H_WBFN, H_DONE:
					wr_req_q <= 1'b0;
			endcase
		end
	end

	// ********************
	// Link status and events
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || start_q)
		begin
			link_up_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			if (st_q == H_WBFN && synced && rxs[RXS_HFN_BIT] && rxs[RXS_BFN_BIT])
				link_up_q <= 1'b1;
			if (st_q == H_WMAP && lnk.wr_ack)
				done_q <= 1'b1;
		end
	end

	assign ev[IRQ_LINK_UP] = st_q == H_WBFN && synced && rxs[RXS_HFN_BIT] && rxs[RXS_BFN_BIT];
	assign ev[IRQ_DONE] = st_q == H_WMAP && lnk.wr_ack;
	assign stat_rd = i_axi_arvalid && o_axi_arready && i_axi_araddr == REG_IRQ_STAT;

	// Set beats the clear-on-read, so an event in the read cycle stays pending
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | ev;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat_q & irq_mask_q);
	end

	// ********************
	// AXI4-Lite write channel
	// ********************
	assign do_write = !o_axi_awready && !o_axi_wready && !o_axi_bvalid;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_axi_awready <= 1'b1;
			o_axi_wready <= 1'b1;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else
		begin
			if (i_axi_awvalid && o_axi_awready)
			begin
				o_axi_awready <= 1'b0;
				awaddr_q <= i_axi_awaddr;
			end
			if (i_axi_wvalid && o_axi_wready)
			begin
				o_axi_wready <= 1'b0;
				wdata_q <= i_axi_wdata;
				wstrb_q <= i_axi_wstrb;
			end
			if (do_write)
			begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp <= (awaddr_q == REG_CTRL || awaddr_q == REG_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
			end
			if (o_axi_bvalid && i_axi_bready)
			begin
				o_axi_bvalid <= 1'b0;
				o_axi_awready <= 1'b1;
				o_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			start_q <= 1'b0;
			irq_mask_q <= IRQ_MASK_RST;
		end
		else
		begin
			start_q <= do_write && awaddr_q == REG_CTRL && wstrb_q[0] && wdata_q[CTRL_START_BIT];
			if (do_write && awaddr_q == REG_IRQ_MASK && wstrb_q[0])
				irq_mask_q <= wdata_q[IRQ_W-1:0];
		end
	end

	// ********************
	// AXI4-Lite read channel
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_axi_arready <= 1'b1;
			o_axi_rvalid <= 1'b0;
			o_axi_rdata <= '0;
			o_axi_rresp <= RESP_OKAY;
		end
		else if (i_axi_arvalid && o_axi_arready)
		begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid <= 1'b1;
			o_axi_rresp <= RESP_OKAY;
			unique case (i_axi_araddr)
				REG_CTRL:
					o_axi_rdata <= '0;
				REG_STATE:
					o_axi_rdata <= {14'h0000, done_q, link_up_q, rxs, st_q};
				REG_IRQ_STAT:
					o_axi_rdata <= {30'h00000000, irq_stat_q};
				REG_IRQ_MASK:
					o_axi_rdata <= {30'h00000000, irq_mask_q};
				default:
				begin
					o_axi_rdata <= '0;
					o_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (o_axi_rvalid && i_axi_rready)
		begin
			o_axi_rvalid <= 1'b0;
			o_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_link_up <= 1'b0;
		else
			o_link_up <= link_up_q;
	end

	// ********************
	// Link drive
	// ********************
	assign lnk.rst_main = rst_q;
	assign lnk.rst_host = rst_q;
	assign lnk.rst_cfg = rst_q;
	assign lnk.map_tx_rst = {N_CH{rst_q}};
	assign lnk.map_rx_rst = {N_CH{rst_q}};
	assign lnk.wr_req = wr_req_q;
	assign lnk.wr_addr = wr_addr_q;
	assign lnk.wr_data = wr_data_q;
endmodule : clb_seq_end
`default_nettype wire

// >>> shared/clb_pkg.sv
`default_nettype none
package clb_pkg;
	// ********************
	// Timing
	// ********************
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned RST_NS = 500;
	localparam int unsigned RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned NUM_CH = 3;
	// ********************
	// Core register map and values
	// ********************
	localparam logic [15:0] LINK_CFG_ADDR = 16'h0008;
	localparam logic [15:0] MAP_CFG_ADDR = 16'h0100;
	localparam logic [15:0] CHN_CFG_ADDR = 16'h0104;
	localparam logic [31:0] LINK_CFG_VAL = 32'h00000021;
	localparam logic [31:0] CHN_CFG_VAL = 32'h00000301;
	localparam logic [31:0] MAP_CFG_VAL = 32'h0000000c;
	localparam logic [31:0] LINK_CFG_RST = 32'h00000001;
	localparam logic [31:0] MAP_CFG_RST = 32'h00000000;
	localparam logic [31:0] CHN_CFG_RST = 32'h00000000;
	localparam int unsigned LINK_TX_EN_BIT = 0;
	// ********************
	// Extended receive status bus
	// ********************
	localparam int unsigned RXS_W = 8;
	localparam int unsigned RXS_STATE_LSB = 0;
	localparam int unsigned RXS_CNT_LSB = 2;
	localparam int unsigned RXS_BFN_BIT = 6;
	localparam int unsigned RXS_HFN_BIT = 7;
	localparam logic [1:0] RX_OFF = 2'h0;
	localparam logic [1:0] RX_HUNT = 2'h1;
	localparam logic [1:0] RX_SYNCING = 2'h2;
	localparam logic [1:0] RX_HYPERFRAME_SYNCHRONISED = 2'h3;
	localparam logic [2:0] CNT_HUNT = 3'h0;
	localparam logic [2:0] CNT_SYNCING = 3'h1;
	localparam logic [2:0] CNT_AT_SYNC = 3'h2;
	// ********************
	// Sequencer control registers
	// ********************
	localparam int unsigned AXI_AW = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATE = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] REG_IRQ_MASK = 4'hc;
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_LINK_UP = 0;
	localparam int unsigned IRQ_DONE = 1;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ********************
	// State machines
	// ********************
	typedef enum logic [7:0] {
		H_RST = 8'h01,
		H_WSYNC = 8'h02,
		H_WHFN = 8'h04,
		H_WBFN = 8'h08,
		H_WLINK = 8'h10,
		H_WCHN = 8'h20,
		H_WMAP = 8'h40,
		H_DONE = 8'h80
	} clb_host_e;
	typedef enum logic [5:0] {
		D_OFF = 6'h01,
		D_HUNT = 6'h02,
		D_SYNC = 6'h04,
		D_HFNS = 6'h08,
		D_HFN = 6'h10,
		D_UP = 6'h20
	} clb_dev_e;
endpackage : clb_pkg
`default_nettype wire

// >>> shared/clb_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface clb_link_if #(parameter int unsigned N_CH = 3);
	logic rst_main;
	logic rst_host;
	logic rst_cfg;
	logic [N_CH-1:0] map_tx_rst;
	logic [N_CH-1:0] map_rx_rst;
	logic wr_req;
	logic [15:0] wr_addr;
	logic [31:0] wr_data;
	logic wr_ack;
	logic [7:0] rx_status;
	modport seq (
		output rst_main, rst_host, rst_cfg, map_tx_rst, map_rx_rst, wr_req, wr_addr, wr_data,
		input wr_ack, rx_status
	);
	modport core (
		input rst_main, rst_host, rst_cfg, map_tx_rst, map_rx_rst, wr_req, wr_addr, wr_data,
		output wr_ack, rx_status
	);
endinterface : clb_link_if
`default_nettype wire

// >>> rtl/clb_sync.sv
`timescale 1ns/100ps
`default_nettype none
module clb_sync #(parameter int unsigned WIDTH = 1) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] ff1_q;
	logic [WIDTH-1:0] ff2_q;
	logic [WIDTH-1:0] ff3_q;
	// Bits move only where stages two and three agree, so a bit caught mid-change is held back
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			ff1_q <= '0;
			ff2_q <= '0;
			ff3_q <= '0;
			o_sync <= '0;
		end
		else
		begin
			ff1_q <= i_async;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
			o_sync <= (ff2_q & ~(ff2_q ^ ff3_q)) | (o_sync & (ff2_q ^ ff3_q));
		end
	end
endmodule : clb_sync
`default_nettype wire

// >>> rtl/clb_core_end.sv
`timescale 1ns/100ps
`default_nettype none
module clb_core_end import clb_pkg::*; #(
	parameter int unsigned N_CH = NUM_CH,
	parameter int unsigned HUNT_CYC = 8,
	parameter int unsigned SYNC_CYC = 16,
	parameter int unsigned HFN_CYC = 8,
	parameter int unsigned BFN_CYC = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	clb_link_if.core lnk,
	input wire logic i_slave_mode,
	input wire logic i_rx_k285,
	output logic o_tx_k285,
	output logic o_link_up,
	output logic [31:0] o_link_cfg,
	output logic [31:0] o_map_cfg,
	output logic [31:0] o_chn_cfg,
	output logic [N_CH-1:0] o_map_tx_rst,
	output logic [N_CH-1:0] o_map_rx_rst
);
	logic core_rst;
	logic rx_k;
	logic slave_q;
	logic [15:0] cnt_q;
	clb_dev_e st_q;
	logic wr_ack_q;
	logic [31:0] link_cfg_q;
	logic [31:0] map_cfg_q;
	logic [31:0] chn_cfg_q;
	logic [7:0] rxs_q;
	logic ack_ok;

	assign core_rst = i_rst | lnk.rst_main | lnk.rst_host | lnk.rst_cfg;
	assign ack_ok = lnk.wr_req & ~wr_ack_q;

	clb_sync #(.WIDTH(1)) u_rx_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_async(i_rx_k285),
		.o_sync(rx_k)
	);

	// The mode strap is a pin, so it is filtered like the receive line and survives core restarts
	clb_sync #(.WIDTH(1)) u_mode_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_async(i_slave_mode),
		.o_sync(slave_q)
	);

	// ********************
	// Register writes
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (core_rst)
		begin
			wr_ack_q <= 1'b0;
			link_cfg_q <= LINK_CFG_RST;
			map_cfg_q <= MAP_CFG_RST;
			chn_cfg_q <= CHN_CFG_RST;
		end
		else
		begin
			wr_ack_q <= ack_ok;
			if (ack_ok && lnk.wr_addr == LINK_CFG_ADDR)
				link_cfg_q <= lnk.wr_data;
			if (ack_ok && lnk.wr_addr == MAP_CFG_ADDR)
				map_cfg_q <= lnk.wr_data;
			if (ack_ok && lnk.wr_addr == CHN_CFG_ADDR)
				chn_cfg_q <= lnk.wr_data;
		end
	end

	// ********************
	// Receiver frame synchronisation
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (core_rst)
		begin
			st_q <= D_OFF;
			cnt_q <= '0;
		end
		else if (!rx_k && st_q != D_OFF)
		begin
			st_q <= D_HUNT;
			cnt_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_q + 16'h0001;
			unique case (st_q)
				D_OFF:
				begin
					st_q <= D_HUNT;
					cnt_q <= '0;
				end
				D_HUNT:
					if (cnt_q >= 16'(HUNT_CYC - 1))
					begin
						st_q <= D_SYNC;
						cnt_q <= '0;
					end
				D_SYNC:
					if (cnt_q >= 16'(SYNC_CYC - 1))
					begin
						st_q <= D_HFNS;
						cnt_q <= '0;
					end
				D_HFNS:
					if (cnt_q >= 16'(HFN_CYC - 1))
					begin
						st_q <= D_HFN;
						cnt_q <= '0;
					end
				D_HFN:
					if (cnt_q >= 16'(BFN_CYC - 1))
					begin
						st_q <= D_UP;
						cnt_q <= '0;
					end
				D_UP:
					cnt_q <= cnt_q;
			endcase
		end
	end

	// ********************
	// Status bus and outputs
	// ********************
	always_ff @(posedge i_clk_sys)
	begin
		if (core_rst)
			rxs_q <= '0;
		else
		begin
			rxs_q <= '0;
			unique case (st_q)
				D_OFF:
					rxs_q[RXS_STATE_LSB +: 2] <= RX_OFF;
				D_HUNT:
				begin
					rxs_q[RXS_STATE_LSB +: 2] <= RX_HUNT;
					rxs_q[RXS_CNT_LSB +: 3] <= CNT_HUNT;
				end
				D_SYNC:
				begin
					rxs_q[RXS_STATE_LSB +: 2] <= RX_SYNCING;
					rxs_q[RXS_CNT_LSB +: 3] <= CNT_SYNCING;
				end
				D_HFNS, D_HFN, D_UP:
				begin
					rxs_q[RXS_STATE_LSB +: 2] <= RX_HYPERFRAME_SYNCHRONISED;
					rxs_q[RXS_CNT_LSB +: 3] <= CNT_AT_SYNC;
					rxs_q[RXS_HFN_BIT] <= (st_q != D_HFNS);
					rxs_q[RXS_BFN_BIT] <= (st_q == D_UP);
				end
			endcase
		end
	end

	// A slave never starts the link on its own, so it cannot come up looped to itself
	always_ff @(posedge i_clk_sys)
	begin
		if (core_rst)
			o_tx_k285 <= 1'b0;
		else
			o_tx_k285 <= link_cfg_q[LINK_TX_EN_BIT] && (!slave_q || (st_q != D_HUNT && st_q != D_OFF));
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_link_up <= 1'b0;
			o_link_cfg <= LINK_CFG_RST;
			o_map_cfg <= MAP_CFG_RST;
			o_chn_cfg <= CHN_CFG_RST;
			o_map_tx_rst <= '1;
			o_map_rx_rst <= '1;
		end
		else
		begin
			o_link_up <= (st_q == D_UP);
			o_link_cfg <= link_cfg_q;
			o_map_cfg <= map_cfg_q;
			o_chn_cfg <= chn_cfg_q;
			o_map_tx_rst <= lnk.map_tx_rst;
			o_map_rx_rst <= lnk.map_rx_rst;
		end
	end

	assign lnk.wr_ack = wr_ack_q;
	assign lnk.rx_status = rxs_q;
endmodule : clb_core_end
`default_nettype wire

// >>> testbench/clb_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module clb_link_assertions import clb_pkg::*; #(parameter int unsigned N_CH = 3) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic rst_main,
	input wire logic rst_host,
	input wire logic rst_cfg,
	input wire logic [N_CH-1:0] map_tx_rst,
	input wire logic [N_CH-1:0] map_rx_rst,
	input wire logic wr_req,
	input wire logic [15:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_ack,
	input wire logic [7:0] rx_status
);
	// ********************
	// Helpers
	// ********************
	int unsigned rst_cnt_q;
	logic seen_link_q;
	logic seen_chn_q;
	// Saturates so a long hold cannot wrap
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || !rst_main)
			rst_cnt_q <= 0;
		else if (rst_cnt_q < 1000)
			rst_cnt_q <= rst_cnt_q + 1;
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || rst_main)
		begin
			seen_link_q <= 1'b0;
			seen_chn_q <= 1'b0;
		end
		else if (wr_ack && wr_addr == LINK_CFG_ADDR)
			seen_link_q <= 1'b1;
		else if (wr_ack && wr_addr == CHN_CFG_ADDR)
			seen_chn_q <= 1'b1;
	end
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_req_open;
		$rose(wr_req);
	endsequence
	sequence s_acked;
		##1 wr_ack ##1 !wr_req;
	endsequence
	a_resets_together: assert property (
		rst_host == rst_main && rst_cfg == rst_main && map_tx_rst == {N_CH{rst_main}} && map_rx_rst == {N_CH{rst_main}})
		else $error("core resets differ");
	a_reset_long: assert property ($fell(rst_main) |-> rst_cnt_q >= RST_CYC)
		else $error("core reset too short");
	a_state_steps: assert property (
		($changed(rx_status[1:0]) && rx_status[1:0] > 2'h1) |-> rx_status[1:0] == $past(rx_status[1:0]) + 2'h1)
		else $error("rx state skipped a step");
	a_synced_count: assert property (rx_status[1:0] == 2'h3 |-> rx_status[4:2] == 3'h2)
		else $error("sync count wrong in synced state");
	a_hfn_first: assert property ($rose(rx_status[6]) |-> $past(rx_status[7]) && rx_status[1:0] == 2'h3)
		else $error("basic frame valid before hyperframe valid");
	a_write_after_up: assert property (wr_req |-> rx_status[7:6] == 2'h3 && rx_status[1:0] == 2'h3)
		else $error("write before link up");
	a_write_values: assert property (wr_req |-> (wr_addr == LINK_CFG_ADDR && wr_data == LINK_CFG_VAL) ||
		(wr_addr == CHN_CFG_ADDR && wr_data == CHN_CFG_VAL) || (wr_addr == MAP_CFG_ADDR && wr_data == MAP_CFG_VAL))
		else $error("bad config write");
	a_write_order: assert property (wr_req |-> wr_addr == LINK_CFG_ADDR ||
		(wr_addr == CHN_CFG_ADDR && seen_link_q) || (wr_addr == MAP_CFG_ADDR && seen_chn_q))
		else $error("config writes out of order");
	a_req_acked: assert property (s_req_open |-> s_acked)
		else $error("write handshake broken");
	a_req_holds: assert property ((wr_req && !wr_ack) |=> wr_req && $stable(wr_addr) && $stable(wr_data))
		else $error("write request dropped early");
endmodule : clb_link_assertions
`default_nettype wire

// >>> testbench/tb_cpri_link_bringup_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cpri_link_bringup_sequencer import clb_pkg::*;;
	// ********************
	// Stimulus and wiring
	// ********************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic mode = 1'b0;
	logic loop = 1'b1;
	logic kin = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, seq_up, tx_k, core_up, rxk;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, link_cfg, map_cfg, chn_cfg;
	logic [NUM_CH-1:0] mtx, mrx;
	int miscompares = 0;
	int total_checks = 0;
	// Far end of the line is either our own transmitter or a bench-driven partner
	assign rxk = loop ? tx_k : kin;
	always #12.5 clk = ~clk;
	clb_link_if #(.N_CH(NUM_CH)) link ();
	clb_seq_end #(.N_CH(NUM_CH)) clb_seq_end_i (.i_clk_sys(clk), .i_rst(rst), .lnk(link),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
		.i_axi_wstrb(4'hf), .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
		.o_axi_bvalid(bvalid), .i_axi_bready(1'b1), .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
		.o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
		.i_axi_rready(1'b1), .o_irq(irq), .o_link_up(seq_up));
	clb_core_end #(.N_CH(NUM_CH)) clb_core_end_i (.i_clk_sys(clk), .i_rst(rst), .lnk(link),
		.i_slave_mode(mode), .i_rx_k285(rxk), .o_tx_k285(tx_k), .o_link_up(core_up), .o_link_cfg(link_cfg),
		.o_map_cfg(map_cfg), .o_chn_cfg(chn_cfg), .o_map_tx_rst(mtx), .o_map_rx_rst(mrx));
	clb_link_assertions #(.N_CH(NUM_CH)) clb_link_assertions_i (.i_clk_sys(clk), .i_rst(rst),
		.rst_main(link.rst_main), .rst_host(link.rst_host), .rst_cfg(link.rst_cfg), .map_tx_rst(link.map_tx_rst),
		.map_rx_rst(link.map_rx_rst), .wr_req(link.wr_req), .wr_addr(link.wr_addr), .wr_data(link.wr_data),
		.wr_ack(link.wr_ack), .rx_status(link.rx_status));
	// ********************
	// Shared tasks
	// ********************
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// Both channels offered together; each dropped at its own handshake
	task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (n < 50)
		begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				r = bresp;
				n = 99;
			end
		end
		check("bvalid", 32'(n == 99), 32'h1);
	endtask : axi_wr
	task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		d = 32'h0;
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		while (n < 50)
		begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				r = rresp;
				n = 99;
			end
		end
		check("rvalid", 32'(n == 99), 32'h1);
	endtask : axi_rd
	// ********************
	// Scenarios
	// ********************
	task t_reset;
		int n;
		check("map_rst", 32'({mtx, mrx}), 32'h3f);
		check("link_cfg_rst", link_cfg, LINK_CFG_RST);
		check("map_cfg_rst", map_cfg, MAP_CFG_RST);
		check("chn_cfg_rst", chn_cfg, CHN_CFG_RST);
		rst <= 1'b0;
		for (n = 0; n < 100 && link.rst_main !== 1'b0; n++)
			@(posedge clk);
		check("rst_len", 32'(n >= RST_CYC), 32'h1);
		$display("test reset done");
	endtask : t_reset
	task t_bringup(input string name);
		int n;
		logic [1:0] r;
		logic [31:0] d;
		// A restart leaves the old link up for a few cycles
		for (n = 0; n < 100 && core_up !== 1'b0; n++)
			@(posedge clk);
		for (n = 0; n < 2000 && core_up !== 1'b1; n++)
			@(posedge clk);
		check("cfg_at_up", link_cfg, LINK_CFG_RST);
		d = 32'h0;
		for (n = 0; n < 100 && d[17] !== 1'b1; n++)
			axi_rd(REG_STATE, d, r);
		check("state", d, 32'h0003cb80);
		check("link_cfg", link_cfg, LINK_CFG_VAL);
		check("chn_cfg", chn_cfg, CHN_CFG_VAL);
		check("map_cfg", map_cfg, MAP_CFG_VAL);
		check("tx_k285", 32'(tx_k), 32'h1);
		check("seq_up", 32'(seq_up), 32'h1);
		check("map_rel", 32'({mtx, mrx}), 32'h0);
		$display("test %s done", name);
	endtask : t_bringup
	task t_irq;
		logic [1:0] r;
		logic [31:0] d;
		axi_rd(REG_IRQ_MASK, d, r);
		check("mask_rst", d, 32'(IRQ_MASK_RST));
		check("irq_masked", 32'(irq), 32'h0);
		axi_wr(REG_IRQ_MASK, 32'h3, r);
		check("mask_resp", 32'(r), 32'(RESP_OKAY));
		repeat (2) @(posedge clk);
		check("irq_on", 32'(irq), 32'h1);
		axi_rd(REG_IRQ_STAT, d, r);
		check("irq_stat", d, 32'h3);
		check("stat_resp", 32'(r), 32'(RESP_OKAY));
		repeat (2) @(posedge clk);
		check("irq_off", 32'(irq), 32'h0);
		axi_rd(REG_IRQ_STAT, d, r);
		check("stat_clr", d, 32'h0);
		axi_wr(REG_STATE, 32'h1, r);
		check("ro_resp", 32'(r), 32'(RESP_SLVERR));
		axi_rd(4'h2, d, r);
		check("bad_rd", 32'(r), 32'(RESP_SLVERR));
		check("bad_rd_data", d, 32'h0);
		$display("test irq done");
	endtask : t_irq
	// A slave looped onto itself must stay silent; a live partner brings it up
	task t_slave;
		logic [1:0] r;
		logic txs;
		mode <= 1'b1;
		axi_wr(REG_CTRL, 32'h1, r);
		// Let the restart reach the core before watching its transmitter
		repeat (4) @(posedge clk);
		txs = 1'b0;
		repeat (300)
		begin
			@(posedge clk);
			txs = txs | tx_k;
		end
		check("slave_tx", 32'(txs), 32'h0);
		check("slave_up", 32'(core_up), 32'h0);
		kin <= 1'b1;
		loop <= 1'b0;
		t_bringup("slave");
		mode <= 1'b0;
		loop <= 1'b1;
		axi_wr(REG_CTRL, 32'h1, r);
		t_bringup("restart");
	endtask : t_slave
	initial
	begin
		#200000;
		miscompares++;
		$display("Error watchdog expected finish seen hang");
		stop_test();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		t_reset();
		t_bringup("master");
		t_irq();
		t_slave();
		stop_test();
	end
endmodule : tb_cpri_link_bringup_sequencer
`default_nettype wire
